// [rtl/emas_pin_sync.sv]
// Three-stage input synchroniser with agreement filter, one per bit
`timescale 1ns/1ns
`default_nettype none
module emas_pin_sync #(
	parameter int W = 16
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic s1_ff, s2_ff, s3_ff, q_ff;
		// Stage one feeds only stage two; the filter looks at stages two and three
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				s1_ff <= 1'b0;
				s2_ff <= 1'b0;
				s3_ff <= 1'b0;
				q_ff <= 1'b0;
			end else begin
				s1_ff <= din[i];
				s2_ff <= s1_ff;
				s3_ff <= s2_ff;
				if (s2_ff == s3_ff) q_ff <= s3_ff;
			end
		end
		assign dout[i] = q_ff;
	end
endmodule : emas_pin_sync
`default_nettype wire

// [rtl/emas_pkg.sv]
// Shared constants, kind codes and timing tables for the memory sequencer
package emas_pkg;
	// Clock rates; the static interface tick is derived from their ratio
	localparam int SYS_CLK_MHZ = 100;
	localparam int SM_CLK_MHZ = 75;

	localparam int ADDR_W = 22;
	localparam int SD_COL_W = 9;
	localparam int SD_ROW_W = 13;
	localparam int DQ_W = 16;
	localparam int KIND_W = 3;

	// Access kinds presented by the router
	localparam logic [2:0] KIND_RD1 = 3'h0;
	localparam logic [2:0] KIND_WR1 = 3'h1;
	localparam logic [2:0] KIND_RD2 = 3'h2;
	localparam logic [2:0] KIND_WR2 = 3'h3;
	localparam logic [2:0] KIND_FETCH = 3'h4;
	localparam logic [2:0] KIND_FILL = 3'h5;

	localparam logic [4:0] WORDS_SINGLE = 5'h01;
	localparam logic [4:0] WORDS_DOUBLE = 5'h02;
	localparam logic [4:0] WORDS_LINE = 5'h08;

	// SDRAM timing in router clocks, counted from the column command; SD_ACT_TO_CMD from the activate
	localparam logic [4:0] SD_ACT_TO_CMD = 5'h03;
	localparam logic [4:0] SD_LATCH_FIRST = 5'h03;
	localparam logic [4:0] SD_STOP_SINGLE = 5'h01;
	localparam logic [4:0] SD_STOP_DOUBLE = 5'h02;
	localparam logic [4:0] SD_STOP_LINE = 5'h08;
	localparam logic [4:0] SD_WR_PERIOD = 5'h04;
	localparam logic [4:0] SD_RD_PERIOD = 5'h0a;
	localparam logic [4:0] SD_FILL_PERIOD = 5'h14;

	// Static memory timing in interface clocks
	localparam logic [2:0] SM_RD_SLOT = 3'h6;
	localparam logic [2:0] SM_WE_LEAD = 3'h1;
	localparam logic [2:0] SM_WE_LOW = 3'h5;
	localparam logic [2:0] SM_WR_SLOT = 3'h7;
	localparam logic [3:0] SM_RD_GAP = 4'h5;
	localparam logic [3:0] SM_WR_GAP = 4'h4;
	localparam logic [3:0] SM_FILL_GAP = 4'ha;

	function automatic logic kind_write(input logic [2:0] k);
		return (k == KIND_WR1) || (k == KIND_WR2);
	endfunction : kind_write

	// Fetch falls to the double-word entries
	function automatic logic [4:0] kind_words(input logic [2:0] k);
		case (k)
			KIND_RD1, KIND_WR1: return WORDS_SINGLE;
			KIND_FILL: return WORDS_LINE;
			default: return WORDS_DOUBLE;
		endcase
	endfunction : kind_words

	function automatic logic [4:0] sd_period(input logic [2:0] k);
		case (k)
			KIND_WR1, KIND_WR2: return SD_WR_PERIOD;
			KIND_FILL: return SD_FILL_PERIOD;
			default: return SD_RD_PERIOD;
		endcase
	endfunction : sd_period

	function automatic logic [4:0] sd_stop(input logic [2:0] k);
		case (k)
			KIND_RD1, KIND_WR1: return SD_STOP_SINGLE;
			KIND_FILL: return SD_STOP_LINE;
			default: return SD_STOP_DOUBLE;
		endcase
	endfunction : sd_stop

	function automatic logic [3:0] sm_gap(input logic [2:0] k);
		case (k)
			KIND_WR1, KIND_WR2: return SM_WR_GAP;
			KIND_FILL: return SM_FILL_GAP;
			default: return SM_RD_GAP;
		endcase
	endfunction : sm_gap
endpackage : emas_pkg

// [rtl/emas_sm_if.sv]
// Request and response bundle between the top and the static memory sequencer
`timescale 1ns/1ns
`default_nettype none
interface emas_sm_if;
	logic req_valid;
	logic req_ready;
	logic [emas_pkg::KIND_W-1:0] req_kind;
	logic [emas_pkg::ADDR_W-1:0] req_addr;
	logic [31:0] req_wdata;
	logic rsp_valid;
	logic [emas_pkg::DQ_W-1:0] rsp_data;
	logic rsp_last;
	modport seq (input req_valid, req_kind, req_addr, req_wdata,
		output req_ready, rsp_valid, rsp_data, rsp_last);
	modport ctl (output req_valid, req_kind, req_addr, req_wdata,
		input req_ready, rsp_valid, rsp_data, rsp_last);
endinterface : emas_sm_if
`default_nettype wire

// [rtl/emas_sm_seq.sv]
// Static memory strobe sequencer running on a derived interface-clock tick
`timescale 1ns/1ns
`default_nettype none
module emas_sm_seq (
	input wire logic sys_clk,
	input wire logic sys_rst,
	emas_sm_if.seq bus,
	output logic sm_ce_n,
	output logic sm_oe_n,
	output logic sm_we_n,
	output logic [emas_pkg::ADDR_W-1:0] sm_addr,
	output logic [emas_pkg::DQ_W-1:0] sm_dq_o,
	output logic sm_dq_oe,
	input wire logic [emas_pkg::DQ_W-1:0] sm_dq_i
);
	typedef enum logic [3:0] {
		SM_IDLE = 4'h1, SM_START = 4'h2, SM_ACTIVE = 4'h4, SM_RECOV = 4'h8
	} emas_sm_state_e;
	localparam logic [7:0] TICK_INC = 8'(emas_pkg::SM_CLK_MHZ);
	localparam logic [7:0] TICK_MOD = 8'(emas_pkg::SYS_CLK_MHZ);

	emas_sm_state_e st_ff, nxt_st;
	logic [7:0] acc_ff;
	logic [2:0] kind_ff, slot_ff, nxt_slot;
	logic [4:0] word_ff, nxt_word;
	logic [3:0] rec_ff, nxt_rec;
	logic [emas_pkg::ADDR_W-1:0] base_ff;
	logic [31:0] wdata_ff;
	logic ce_n_ff, oe_n_ff, we_n_ff, dq_oe_ff, rsp_valid_ff, rsp_last_ff;
	logic [emas_pkg::ADDR_W-1:0] addr_ff;
	logic [emas_pkg::DQ_W-1:0] dq_o_ff, rsp_data_ff, dq_filt;

	// Fractional accumulator: 75 ticks per 100 system clocks
	wire [7:0] acc_sum = acc_ff + TICK_INC;
	wire tick = acc_sum >= TICK_MOD;
	wire [7:0] nxt_acc = tick ? acc_sum - TICK_MOD : acc_sum;

	wire accept = bus.req_valid && st_ff == SM_IDLE;
	wire [2:0] nxt_kind = accept ? bus.req_kind : kind_ff;
	wire [emas_pkg::ADDR_W-1:0] nxt_base = accept ? bus.req_addr : base_ff;
	wire [31:0] nxt_wdata = accept ? bus.req_wdata : wdata_ff;
	wire wr = emas_pkg::kind_write(kind_ff);
	wire [2:0] slot_len = wr ? emas_pkg::SM_WR_SLOT : emas_pkg::SM_RD_SLOT;
	wire slot_end = slot_ff == slot_len - 3'h1;
	wire word_end = word_ff == emas_pkg::kind_words(kind_ff) - 5'h01;
	wire [3:0] gap = emas_pkg::sm_gap(kind_ff);
	wire rd_done = tick && st_ff == SM_ACTIVE && !wr && slot_end;

	// Strobe sequencing; the tick spent in idle completes the recovery gap
	always_comb begin
		nxt_st = st_ff;
		nxt_slot = slot_ff;
		nxt_word = word_ff;
		nxt_rec = rec_ff;
		case (st_ff)
			SM_IDLE: begin
				if (accept) nxt_st = tick ? SM_ACTIVE : SM_START;
				nxt_slot = 3'h0;
				nxt_word = 5'h00;
			end
			SM_START: if (tick) nxt_st = SM_ACTIVE;
			SM_ACTIVE: if (tick) begin
				if (!slot_end) begin
					nxt_slot = slot_ff + 3'h1;
				end else if (!word_end) begin
					nxt_slot = 3'h0;
					nxt_word = word_ff + 5'h01;
				end else begin
					nxt_st = SM_RECOV;
					nxt_rec = 4'h0;
				end
			end
			SM_RECOV: if (tick) begin
				if (rec_ff == gap - 4'h2) nxt_st = SM_IDLE;
				else nxt_rec = rec_ff + 4'h1;
			end
			default: nxt_st = SM_IDLE;
		endcase
	end

	// Pin values for the coming cycle
	wire nx_act = nxt_st == SM_ACTIVE;
	wire nx_wr = emas_pkg::kind_write(nxt_kind);
	wire nx_we = nx_act && nx_wr && nxt_slot >= emas_pkg::SM_WE_LEAD
		&& nxt_slot < emas_pkg::SM_WE_LEAD + emas_pkg::SM_WE_LOW;
	wire [emas_pkg::ADDR_W-1:0] nx_addr = nxt_base + emas_pkg::ADDR_W'(nxt_word);
	wire [15:0] nx_dq = nxt_word[0] ? nxt_wdata[31:16] : nxt_wdata[15:0];

	emas_pin_sync #(.W(emas_pkg::DQ_W)) u_dq_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.din(sm_dq_i),
		.dout(dq_filt)
	);

	// State, request hold and registered pins
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_ff <= SM_IDLE;
			acc_ff <= 8'h00;
			kind_ff <= 3'h0;
			slot_ff <= 3'h0;
			word_ff <= 5'h00;
			rec_ff <= 4'h0;
			base_ff <= '0;
			wdata_ff <= 32'h0;
			ce_n_ff <= 1'b1;
			oe_n_ff <= 1'b1;
			we_n_ff <= 1'b1;
			dq_oe_ff <= 1'b0;
			addr_ff <= '0;
			dq_o_ff <= 16'h0;
		end else begin
			st_ff <= nxt_st;
			acc_ff <= nxt_acc;
			kind_ff <= nxt_kind;
			slot_ff <= nxt_slot;
			word_ff <= nxt_word;
			rec_ff <= nxt_rec;
			base_ff <= nxt_base;
			wdata_ff <= nxt_wdata;
			ce_n_ff <= !nx_act;
			oe_n_ff <= !(nx_act && !nx_wr);
			we_n_ff <= !nx_we;
			dq_oe_ff <= nx_act && nx_wr;
			addr_ff <= nx_addr;
			dq_o_ff <= nx_dq;
		end
	end

	// Read data is taken at the final tick of each word's strobe
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rsp_valid_ff <= 1'b0;
			rsp_last_ff <= 1'b0;
			rsp_data_ff <= 16'h0;
		end else begin
			rsp_valid_ff <= rd_done;
			rsp_last_ff <= rd_done && word_end;
			if (rd_done) rsp_data_ff <= dq_filt;
		end
	end

	assign bus.req_ready = st_ff == SM_IDLE;
	assign bus.rsp_valid = rsp_valid_ff;
	assign bus.rsp_data = rsp_data_ff;
	assign bus.rsp_last = rsp_last_ff;
	assign sm_ce_n = ce_n_ff;
	assign sm_oe_n = oe_n_ff;
	assign sm_we_n = we_n_ff;
	assign sm_addr = addr_ff;
	assign sm_dq_o = dq_o_ff;
	assign sm_dq_oe = dq_oe_ff;
endmodule : emas_sm_seq
`default_nettype wire

// [rtl/emas_top.sv]
// External memory access sequencer: request slot, SDRAM sequencer, static port
//
// Summary of operation
// - Write command three clocks after activate
// - Write data driven with the write command
// - Single write: burst stop the next clock
// - Single writes repeat every four clocks
// - New row write adds three-clock activate
// - Double read: stop at two, latch at three and four
// - Double reads repeat every ten clocks
// - Double write: two data, stop, one idle
// - Uncached fetch equals double read, ten clocks
// - Line fill: eight words, latched clocks 3-10
// - Fill: stop at eight, repeat every twenty
// - Static port counts 75 MHz ticks
// - Static single read: six active, eleven period
// - Static write: strobe five, seven total
// - Static writes: four idle, eleven period
// - Static double read: twelve active, seventeen
// - Static double write: 5-2-5, eighteen total
// - Static uncached fetch equals double read
// - SDRAM clocked at router clock rate
// - Single read: stop next, latch third clock
// - Read to other row adds activate
`timescale 1ns/1ns
`default_nettype none
module emas_top (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_to_static,
	input wire logic [emas_pkg::KIND_W-1:0] req_kind,
	input wire logic [emas_pkg::ADDR_W-1:0] req_addr,
	input wire logic [31:0] req_wdata,
	output logic rsp_valid,
	output logic [emas_pkg::DQ_W-1:0] rsp_data,
	output logic rsp_last,
	output logic sd_ras_n,
	output logic sd_cas_n,
	output logic sd_we_n,
	output logic [emas_pkg::SD_ROW_W-1:0] sd_addr,
	output logic [emas_pkg::DQ_W-1:0] sd_dq_o,
	output logic sd_dq_oe,
	input wire logic [emas_pkg::DQ_W-1:0] sd_dq_i,
	output logic sm_ce_n,
	output logic sm_oe_n,
	output logic sm_we_n,
	output logic [emas_pkg::ADDR_W-1:0] sm_addr,
	output logic [emas_pkg::DQ_W-1:0] sm_dq_o,
	output logic sm_dq_oe,
	input wire logic [emas_pkg::DQ_W-1:0] sm_dq_i
);
	localparam int AW = emas_pkg::ADDR_W;
	localparam int CW = emas_pkg::SD_COL_W;
	localparam int RW = emas_pkg::SD_ROW_W;

	typedef enum logic [2:0] {
		SD_IDLE = 3'h1, SD_ACT = 3'h2, SD_XFER = 3'h4
	} emas_sd_state_e;

	emas_sm_if sm_bus ();

	// One-entry request slot; its fullness is the back-pressure to the router
	logic pend_vld_ff, pend_sm_ff, req_ready_ff;
	logic [2:0] pend_kind_ff;
	logic [AW-1:0] pend_addr_ff;
	logic [31:0] pend_wdata_ff;

	// SDRAM sequencer state
	emas_sd_state_e sd_state_ff, nxt_sd_state;
	logic [4:0] sd_cnt_ff, nxt_sd_cnt;
	logic [2:0] sd_kind_ff, nxt_sd_kind;
	logic [AW-1:0] sd_addr_q_ff, nxt_sd_addr_q;
	logic [31:0] sd_wdata_ff, nxt_sd_wdata;
	logic row_open_ff;
	logic [RW-1:0] open_row_ff;

	// Registered pins and response
	logic ras_n_ff, cas_n_ff, we_n_ff, dq_oe_ff;
	logic [RW-1:0] sd_addr_ff;
	logic [15:0] dq_o_ff, rsp_data_ff;
	logic rsp_valid_ff, rsp_last_ff;

	// Slot bookkeeping and dispatch decisions
	wire accept = req_valid && req_ready_ff;
	wire [RW-1:0] pend_row = pend_addr_ff[AW-1:CW];
	wire row_hit = row_open_ff && pend_row == open_row_ff;
	wire [4:0] sd_period = emas_pkg::sd_period(sd_kind_ff);
	wire sd_last = sd_state_ff == SD_XFER && sd_cnt_ff == sd_period - 5'h01;
	wire sd_free = sd_state_ff == SD_IDLE || sd_last;
	// Ports never run together, so their responses cannot collide
	wire take_sd = pend_vld_ff && !pend_sm_ff && sd_free && sm_bus.req_ready;
	wire take_sm = pend_vld_ff && pend_sm_ff && sm_bus.req_ready && sd_state_ff == SD_IDLE;
	wire nxt_pend_vld = accept || (pend_vld_ff && !(take_sd || take_sm));

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pend_vld_ff <= 1'b0;
			req_ready_ff <= 1'b1;
			pend_sm_ff <= 1'b0;
			pend_kind_ff <= 3'h0;
			pend_addr_ff <= '0;
			pend_wdata_ff <= 32'h0;
		end else begin
			pend_vld_ff <= nxt_pend_vld;
			req_ready_ff <= !nxt_pend_vld;
			if (accept) begin
				pend_sm_ff <= req_to_static;
				pend_kind_ff <= req_kind;
				pend_addr_ff <= req_addr;
				pend_wdata_ff <= req_wdata;
			end
		end
	end

	// SDRAM sequencing; the counter restarts at zero on the column command
	always_comb begin
		nxt_sd_state = sd_state_ff;
		nxt_sd_cnt = sd_cnt_ff + 5'h01;
		nxt_sd_kind = sd_kind_ff;
		nxt_sd_addr_q = sd_addr_q_ff;
		nxt_sd_wdata = sd_wdata_ff;
		case (sd_state_ff)
			SD_ACT: begin
				if (sd_cnt_ff == emas_pkg::SD_ACT_TO_CMD - 5'h01) begin
					nxt_sd_state = SD_XFER;
					nxt_sd_cnt = 5'h00;
				end
			end
			SD_XFER: if (sd_last) nxt_sd_state = SD_IDLE;
			default: nxt_sd_cnt = sd_cnt_ff;
		endcase
		if (take_sd) begin
			nxt_sd_kind = pend_kind_ff;
			nxt_sd_addr_q = pend_addr_ff;
			nxt_sd_wdata = pend_wdata_ff;
			nxt_sd_cnt = 5'h00;
			nxt_sd_state = row_hit ? SD_XFER : SD_ACT;
		end
	end

	// Command decode for the coming cycle, so pins leave straight from flops
	wire nx_xfer = nxt_sd_state == SD_XFER;
	wire nx_wr = emas_pkg::kind_write(nxt_sd_kind);
	wire nx_act = nxt_sd_state == SD_ACT && nxt_sd_cnt == 5'h00;
	wire nx_cmd = nx_xfer && nxt_sd_cnt == 5'h00;
	wire nx_stop = nx_xfer && nxt_sd_cnt == emas_pkg::sd_stop(nxt_sd_kind);
	wire nx_drive = nx_xfer && nx_wr
		&& nxt_sd_cnt < emas_pkg::kind_words(nxt_sd_kind);
	wire [RW-1:0] nx_col = {{(RW-CW){1'b0}}, nxt_sd_addr_q[CW-1:0]};
	wire [RW-1:0] nx_addr = nx_act ? nxt_sd_addr_q[AW-1:CW] : nx_col;
	wire [15:0] nx_dq = nxt_sd_cnt[0] ? nxt_sd_wdata[31:16] : nxt_sd_wdata[15:0];

	// Read capture window relative to the column command
	wire sd_rd = sd_state_ff == SD_XFER && !emas_pkg::kind_write(sd_kind_ff);
	wire [4:0] lat_end = emas_pkg::SD_LATCH_FIRST + emas_pkg::kind_words(sd_kind_ff);
	wire sd_latch = sd_rd && sd_cnt_ff >= emas_pkg::SD_LATCH_FIRST
		&& sd_cnt_ff < lat_end;
	wire sd_lastword = sd_cnt_ff == lat_end - 5'h01;

	// Sequencer registers and open-row memory
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sd_state_ff <= SD_IDLE;
			sd_cnt_ff <= 5'h00;
			sd_kind_ff <= 3'h0;
			sd_addr_q_ff <= '0;
			sd_wdata_ff <= 32'h0;
			row_open_ff <= 1'b0;
			open_row_ff <= '0;
		end else begin
			sd_state_ff <= nxt_sd_state;
			sd_cnt_ff <= nxt_sd_cnt;
			sd_kind_ff <= nxt_sd_kind;
			sd_addr_q_ff <= nxt_sd_addr_q;
			sd_wdata_ff <= nxt_sd_wdata;
			if (take_sd && !row_hit) begin
				row_open_ff <= 1'b1;
				open_row_ff <= pend_row;
			end
		end
	end

	// The memory runs on sys_clk itself, hence no synchroniser on its data
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ras_n_ff <= 1'b1;
			cas_n_ff <= 1'b1;
			we_n_ff <= 1'b1;
			dq_oe_ff <= 1'b0;
			sd_addr_ff <= '0;
			dq_o_ff <= 16'h0;
		end else begin
			ras_n_ff <= !nx_act;
			cas_n_ff <= !nx_cmd;
			we_n_ff <= !((nx_cmd && nx_wr) || nx_stop);
			dq_oe_ff <= nx_drive;
			sd_addr_ff <= nx_addr;
			dq_o_ff <= nx_dq;
		end
	end

	// Static port request and response merging
	assign sm_bus.req_valid = take_sm;
	assign sm_bus.req_kind = pend_kind_ff;
	assign sm_bus.req_addr = pend_addr_ff;
	assign sm_bus.req_wdata = pend_wdata_ff;

	wire nxt_rsp_valid = sd_latch || sm_bus.rsp_valid;
	wire [15:0] nxt_rsp_data = sd_latch ? sd_dq_i : sm_bus.rsp_data;
	wire nxt_rsp_last = sd_latch ? sd_lastword : sm_bus.rsp_last;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rsp_valid_ff <= 1'b0;
			rsp_data_ff <= 16'h0;
			rsp_last_ff <= 1'b0;
		end else begin
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_data_ff <= nxt_rsp_data;
			rsp_last_ff <= nxt_rsp_last;
		end
	end

	emas_sm_seq u_sm_seq (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.bus(sm_bus.seq),
		.sm_ce_n(sm_ce_n),
		.sm_oe_n(sm_oe_n),
		.sm_we_n(sm_we_n),
		.sm_addr(sm_addr),
		.sm_dq_o(sm_dq_o),
		.sm_dq_oe(sm_dq_oe),
		.sm_dq_i(sm_dq_i)
	);

	assign req_ready = req_ready_ff;
	assign rsp_valid = rsp_valid_ff;
	assign rsp_data = rsp_data_ff;
	assign rsp_last = rsp_last_ff;
	assign sd_ras_n = ras_n_ff;
	assign sd_cas_n = cas_n_ff;
	assign sd_we_n = we_n_ff;
	assign sd_addr = sd_addr_ff;
	assign sd_dq_o = dq_o_ff;
	assign sd_dq_oe = dq_oe_ff;
endmodule : emas_top
`default_nettype wire

// [test/emas_mem_model.sv]
// Behavioural SDRAM and static RAM on the sequencer's memory pins
`timescale 1ns/1ns
`default_nettype none
module emas_mem_model (
	input wire logic sys_clk,
	input wire logic slow,
	input wire logic sd_ras_n,
	input wire logic sd_cas_n,
	input wire logic sd_we_n,
	input wire logic [12:0] sd_addr,
	input wire logic [15:0] sd_dq_o,
	input wire logic sd_dq_oe,
	output logic [15:0] sd_dq_i,
	input wire logic sm_ce_n,
	input wire logic sm_oe_n,
	input wire logic sm_we_n,
	input wire logic [21:0] sm_addr,
	input wire logic [15:0] sm_dq_o,
	output logic [15:0] sm_dq_i
);
	logic [15:0] sd_mem [int];
	logic [15:0] sm_mem [int];
	logic [12:0] row = 13'h0;
	logic [8:0] col = 9'h0;
	logic rd = 1'b0;
	logic [21:0] wa, ra, sa;
	int k = 99, stk = 99, age = 0;
	// Commands; a read opens a data window from k3 to two clocks past the stop
	always @(posedge sys_clk) begin
		if (!sd_ras_n && sd_cas_n && sd_we_n) row <= sd_addr;
		if (sd_ras_n && !sd_cas_n) begin
			k <= 1;
			stk <= 99;
			rd <= sd_we_n;
			col <= sd_addr[8:0];
		end else begin
			k <= k + 1;
			if (sd_ras_n && sd_cas_n && !sd_we_n) stk <= k;
		end
		if (sd_dq_oe) begin
			wa = (sd_ras_n && !sd_cas_n) ? {row, sd_addr[8:0]} : wa + 22'h1;
			sd_mem[wa] = sd_dq_o;
		end
	end
	// Lines move just after the edge; with nothing valid they toggle, never hold
	always @(posedge sys_clk) begin
		#1;
		ra = {row, col} + 22'(k - 3);
		if (rd && k >= 3 && k <= stk + 2)
			sd_dq_i = sd_mem.exists(ra) ? sd_mem[ra] : ra[15:0] ^ 16'h3c3c;
		else
			sd_dq_i = ~sd_dq_i;
		age = (sm_ce_n || sm_oe_n || sm_addr != sa) ? 0 : age + 1;
		sa = sm_addr;
		if (!sm_ce_n && !sm_we_n) sm_mem[sa] = sm_dq_o;
		// A slow part needs the address steady longer before data appears
		if (age > (slow ? 2 : 0))
			sm_dq_i = sm_mem.exists(sa) ? sm_mem[sa] : sa[15:0] ^ 16'h3c3c;
		else
			sm_dq_i = ~sm_dq_i;
	end
endmodule : emas_mem_model
`default_nettype wire

// [test/emas_top_bench.sv]
// Self-checking bench: round trips, fills, access periods, row tracking, reset
`timescale 1ns/1ns
`default_nettype none
module emas_top_bench;
	typedef struct {
		logic st;
		logic [2:0] kd;
		logic [21:0] a;
		logic [31:0] wd;
		logic [31:0] ex;
	} emas_row_s;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic req_valid = 1'b0;
	logic req_to_static = 1'b0;
	logic [2:0] req_kind = 3'h0;
	logic [21:0] req_addr = 22'h0;
	logic [31:0] req_wdata = 32'h0;
	logic slow = 1'b1;
	logic req_ready, rsp_valid, rsp_last, sd_ras_n, sd_cas_n, sd_we_n, sd_dq_oe;
	logic sm_ce_n, sm_oe_n, sm_we_n, sm_dq_oe;
	logic [15:0] rsp_data, sd_dq_o, sd_dq_i, sm_dq_o, sm_dq_i;
	logic [12:0] sd_addr;
	logic [21:0] sm_addr;
	int n_mismatch = 0, total_checks = 0, cyc = 0, acts = 0, ce_len = 0, run = 0;
	int ev[$];
	logic [15:0] got[$], exq[$];
	// Rows: port, kind, address, write data, expected read words
	emas_row_s rows[11] = '{
		'{1'b0, 3'h1, 22'h000010, 32'h00001234, 32'h0},
		'{1'b0, 3'h1, 22'h000011, 32'h00005678, 32'h0},
		'{1'b0, 3'h3, 22'h000200, 32'hbeefcafe, 32'h0},
		'{1'b0, 3'h0, 22'h000010, 32'h0, 32'h00001234},
		'{1'b0, 3'h2, 22'h000200, 32'h0, 32'hbeefcafe},
		'{1'b0, 3'h4, 22'h000010, 32'h0, 32'h56781234},
		'{1'b1, 3'h1, 22'h000100, 32'h0000a1a1, 32'h0},
		'{1'b1, 3'h3, 22'h000102, 32'hb2b2c3c3, 32'h0},
		'{1'b1, 3'h0, 22'h000100, 32'h0, 32'h0000a1a1},
		'{1'b1, 3'h2, 22'h000102, 32'h0, 32'hb2b2c3c3},
		'{1'b1, 3'h4, 22'h000102, 32'h0, 32'hb2b2c3c3}};
	// Three back-to-back periods in clocks; static ticks are three per four clocks
	int per[12] = '{30, 12, 30, 12, 30, 60, 44, 44, 68, 72, 68, 232};
	int lo[12] = '{0, 0, 0, 0, 0, 0, 8, 0, 16, 0, 16, 64};
	emas_top dut (.sys_clk, .sys_rst, .req_valid, .req_ready, .req_to_static, .req_kind,
		.req_addr, .req_wdata, .rsp_valid, .rsp_data, .rsp_last, .sd_ras_n, .sd_cas_n,
		.sd_we_n, .sd_addr, .sd_dq_o, .sd_dq_oe, .sd_dq_i, .sm_ce_n, .sm_oe_n, .sm_we_n,
		.sm_addr, .sm_dq_o, .sm_dq_oe, .sm_dq_i);
	emas_mem_model mem (.sys_clk, .slow, .sd_ras_n, .sd_cas_n, .sd_we_n, .sd_addr, .sd_dq_o,
		.sd_dq_oe, .sd_dq_i, .sm_ce_n, .sm_oe_n, .sm_we_n, .sm_addr, .sm_dq_o, .sm_dq_i);
	always #5 sys_clk = ~sys_clk;
	// Pin monitor: column commands and static selects as events, read words queued
	always @(posedge sys_clk) begin
		cyc++;
		if (sd_ras_n === 1'b1 && sd_cas_n === 1'b0) ev.push_back(cyc);
		if (sd_ras_n === 1'b0) acts++;
		if (sm_ce_n === 1'b0) begin
			if (run == 0) ev.push_back(cyc);
			run++;
		end else if (run > 0) begin
			ce_len = run;
			run = 0;
		end
		if (rsp_valid === 1'b1) got.push_back(rsp_data);
	end
	task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_word
	task automatic cmp_num(input string nm, input int e, input int g);
		total_checks++;
		if (g != e) begin
			n_mismatch++;
			$display("mismatch %s expected %0d seen %0d", nm, e, g);
		end
	endtask : cmp_num
	task automatic cmp_bit(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask : cmp_bit
	// Holds the request until taken; valid stays up so calls can follow back to back
	task automatic issue(input logic st, input logic [2:0] kd, input logic [21:0] a,
		input logic [31:0] wd);
		logic rdy;
		req_to_static = st;
		req_kind = kd;
		req_addr = a;
		req_wdata = wd;
		req_valid = 1'b1;
		// Ready is read between edges, where it already shows what the next edge samples
		do begin
			rdy = req_ready;
			@(posedge sys_clk);
		end while (rdy !== 1'b1);
		#1;
	endtask : issue
	task automatic check_words();
		for (int i = 0; i < 3000 && got.size() < exq.size(); i++) @(posedge sys_clk);
		cmp_num("word count", exq.size(), got.size());
		foreach (exq[i]) cmp_word("read word", exq[i], got[i]);
		got.delete();
		exq.delete();
		#1;
	endtask : check_words
	task automatic finish_test();
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	// Watchdog well beyond the few thousand clocks the run needs
	initial begin
		#400000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		logic [21:0] a;
		repeat (8) @(posedge sys_clk);
		#1 sys_rst = 1'b0;
		foreach (rows[i]) begin
			issue(rows[i].st, rows[i].kd, rows[i].a, rows[i].wd);
			if (rows[i].kd != 3'h1 && rows[i].kd != 3'h3) begin
				exq.push_back(rows[i].ex[15:0]);
				if (rows[i].kd != 3'h0) exq.push_back(rows[i].ex[31:16]);
			end
		end
		req_valid = 1'b0;
		check_words();
		// Back-to-back fills across both ports with a prompt static part
		slow = 1'b0;
		for (int f = 0; f < 2; f++) begin
			a = f ? 22'h000300 : 22'h000800;
			issue(1'(f), 3'h5, a, 32'h0);
			for (int i = 0; i < 8; i++) exq.push_back(16'(a + 22'(i)) ^ 16'h3c3c);
		end
		req_valid = 1'b0;
		check_words();
		// Every kind on both ports, five queued requests, one row
		for (int p = 0; p < 12; p++) begin
			ev.delete();
			acts = 0;
			for (int j = 0; j < 5; j++) issue(1'(p / 6), 3'(p % 6), {13'h005, 9'(j * 16)}, 32'h0);
			req_valid = 1'b0;
			for (int i = 0; i < 2000 && ev.size() < 5; i++) @(posedge sys_clk);
			#1;
			cmp_num("period", per[p], ev[4] - ev[1]);
			if (p < 6) cmp_num("activates", int'(p == 0), acts);
			if (lo[p] != 0) cmp_num("select length", lo[p], ce_len);
		end
		// Reset in the middle of a static read, then a read must reopen its row
		issue(1'b1, 3'h2, 22'h000102, 32'h0);
		req_valid = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1 sys_rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1 sys_rst = 1'b0;
		cmp_bit("select after reset", 1'b1, sm_ce_n);
		cmp_bit("ready after reset", 1'b1, req_ready);
		cmp_bit("response after reset", 1'b0, rsp_valid);
		got.delete();
		acts = 0;
		issue(1'b0, 3'h2, 22'h000200, 32'h0);
		req_valid = 1'b0;
		exq = '{16'hcafe, 16'hbeef};
		check_words();
		cmp_num("activates after reset", 1, acts);
		finish_test();
	end
endmodule : emas_top_bench
`default_nettype wire

// [test/emas_top_props.sv]
// Pin-level timing checks for the external memory sequencer
`timescale 1ns/1ns
`default_nettype none
module emas_top_props (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic rsp_valid,
	input wire logic rsp_last,
	input wire logic sd_ras_n,
	input wire logic sd_cas_n,
	input wire logic sd_we_n,
	input wire logic sd_dq_oe,
	input wire logic sm_ce_n,
	input wire logic sm_we_n,
	input wire logic sm_dq_oe,
	input wire logic [emas_pkg::ADDR_W-1:0] sm_addr
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// SDRAM commands decoded from the three strobes
	wire act = !sd_ras_n && sd_cas_n && sd_we_n;
	wire nop = sd_ras_n && sd_cas_n && sd_we_n;
	wire stp = sd_ras_n && sd_cas_n && !sd_we_n;
	wire col = sd_ras_n && !sd_cas_n;
	wire rdc = col && sd_we_n;
	wire wrc = col && !sd_we_n;
	wire mid = rsp_valid && !rsp_last;
	wire fin = rsp_valid && rsp_last;
	wire ce = !sm_ce_n;
	// Read bursts are told apart by where the stop lands
	sequence s_rd1; rdc ##1 stp; endsequence
	sequence s_rd2; rdc ##1 nop ##1 stp; endsequence
	sequence s_fill; rdc ##1 nop [*7] ##1 stp; endsequence
	// Within one strobe the address may only step upward by one
	property p_step;
		ce && $past(ce) && $changed(sm_addr) |-> sm_addr == $past(sm_addr) + 22'h1;
	endproperty
	a_act_to_col: assert property (act |-> ##3 col)
		else $error("column command not three clocks after activate");
	a_wr_data_drive: assert property (wrc |-> sd_dq_oe)
		else $error("write command without data driven");
	a_wr_burst_stop: assert property (wrc |-> ##1 (stp or ((nop && sd_dq_oe) ##1 stp)))
		else $error("write burst not stopped in time");
	a_wr_cmd_gap: assert property (wrc |=> !col [*3])
		else $error("write commands closer than four clocks");
	a_rd_cmd_gap: assert property (rdc |=> !col [*8])
		else $error("read commands too close");
	a_rd1_latch: assert property (s_rd1 |-> ##3 fin)
		else $error("single read word late or early");
	a_rd2_latch: assert property (s_rd2 |-> ##2 mid ##1 fin)
		else $error("double read words late or early");
	a_fill_latch: assert property (s_fill |-> ##2 mid ##1 fin)
		else $error("line fill words late or early");
	a_sm_we_lead: assert property ($fell(sm_we_n) |-> ce && !$past(sm_ce_n))
		else $error("static write strobe without lead");
	a_sm_we_tail: assert property ($rose(sm_ce_n) && !$past(sys_rst) |-> $past(sm_we_n))
		else $error("static select released with write strobe low");
	a_sm_ce_idle: assert property ($rose(sm_ce_n) |-> sm_ce_n [*5])
		else $error("static select idle gap too short");
	a_sm_ce_active: assert property ($fell(sm_ce_n) |-> ce [*8])
		else $error("static select active too short");
	a_sm_addr_step: assert property (p_step)
		else $error("static address did not step by one");
	a_sm_dq_drive: assert property (!sm_we_n |-> sm_dq_oe)
		else $error("static write strobe without data driven");
endmodule : emas_top_props
bind emas_top emas_top_props u_props (.sys_clk, .sys_rst, .rsp_valid, .rsp_last, .sd_ras_n,
	.sd_cas_n, .sd_we_n, .sd_dq_oe, .sm_ce_n, .sm_we_n, .sm_dq_oe, .sm_addr);
`default_nettype wire
